// file: rtl/acoc_defines.vh
// Constants for the two-channel comparator output control block
`ifndef ACOC_DEFINES_VH
`define ACOC_DEFINES_VH

`define ACOC_NUM_CMP        2
// Control word one field positions
`define ACOC_CTL_ENABLE     7
`define ACOC_CTL_OUTPUT     6
`define ACOC_CTL_PIN_EN     5
`define ACOC_CTL_INVERT     4
`define ACOC_CTL_SPEED      2
`define ACOC_CTL_HYST       1
`define ACOC_CTL_SYNC       0
// Control word two field positions
`define ACOC_CTL2_RISE      7
`define ACOC_CTL2_FALL      6
// Reset values
`define ACOC_SPEED_RST      1'b1
`define ACOC_CTL1_RST       8'h04
`define ACOC_CTL2_RST       8'h00
// Mirror register bit per comparator
`define ACOC_MIRROR_CMP1    0
`define ACOC_MIRROR_CMP2    1

`endif

// file: rtl/acoc_comparator_ctrl.v
// Digital control and output path for two analog comparators
`timescale 1ns/1ns
`include "acoc_defines.vh"

// What this block does
// - Two comparators, each with own control settings
// - Enable runs comparator; clear means minimum current
// - Result readable in control and mirror bits
// - Comparator drives pin only with pin enable, enable, direction
// - Pin enable overrides port latch, independent of enable
// - Internal result latched each instruction cycle
// - Raw output high when positive above negative
// - Invert flips result before every use
// - Speed select resets high; zero selects low power
// - Hysteresis switch, level depends on speed
// - Result offered to timer as gate source
// - Sync select routes result through timer synchroniser
// - Sync captures on timer clock falling edge
// - Sync uses prescaler output clock
// - Without sync, timer and pin path asynchronous
// - Enabled rising or falling edge sets flag
// - Mirror holds both results, bits one and zero
module acoc_comparator_ctrl #(
  parameter N = `ACOC_NUM_CMP
)(
  input  wire         sys_clk,
  input  wire         arst_n,
  input  wire         clk_en,
  input  wire         instr_cycle_tick,
  input  wire         tmr_presc_clk,
  input  wire [N-1:0] raw_cmp_in,
  input  wire [N-1:0] ctrl_wr_en,
  input  wire [N*8-1:0] ctrl_wr_data,
  input  wire [N-1:0] ctrl2_wr_en,
  input  wire [N*8-1:0] ctrl2_wr_data,
  input  wire [N-1:0] int_flag_clr,
  input  wire [N-1:0] port_latch,
  input  wire [N-1:0] pin_direction_bit,
  output wire [N*8-1:0] comparator_ctrl_first,
  output wire [N*8-1:0] comparator_ctrl_second,
  output wire [7:0]   output_mirror_reg,
  output wire [N-1:0] analog_enable,
  output wire [N-1:0] speed_power_select,
  output wire [N-1:0] hysteresis_enable,
  output wire [N-1:0] timer_gate_src,
  output wire [N-1:0] pin_out,
  output wire [N-1:0] pin_oe,
  output wire [N-1:0] compare_int_flag
);

  // ----------------------------------------------------------------
  // Timer clock edge detection
  // ----------------------------------------------------------------
  // Foreign clock passes three flops; change counts once stages two and three agree
  reg [2:0] tclk_sync_reg;
  reg       tclk_level_reg;
  wire      tclk_fall = (tclk_sync_reg[1] == tclk_sync_reg[2]) && !tclk_sync_reg[2] && tclk_level_reg;

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tclk_sync_reg  <= 3'h0;
      tclk_level_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      tclk_sync_reg <= {tclk_sync_reg[1:0], tmr_presc_clk};
      if (tclk_sync_reg[1] == tclk_sync_reg[2])
        tclk_level_reg <= tclk_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------
  // Per-comparator logic
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_cmp
      reg [7:0] ctl_reg;
      reg [7:0] ctl2_reg;
      reg [2:0] raw_sync_reg;
      reg       inst_out_reg;
      reg       sync_out_reg;
      reg       prev_out_reg;
      reg       flag_reg;
      wire [7:0] wd  = ctrl_wr_data[i*8 +: 8];
      wire [7:0] wd2 = ctrl2_wr_data[i*8 +: 8];
      wire       en  = ctl_reg[`ACOC_CTL_ENABLE];
      // Disabled comparator output reads low, then polarity applies
      wire       raw_q   = raw_sync_reg[2] & en;
      wire       adj     = raw_q ^ ctl_reg[`ACOC_CTL_INVERT];
      wire       ext_res = ctl_reg[`ACOC_CTL_SYNC] ? sync_out_reg : adj;
      wire       rise    = inst_out_reg & ~prev_out_reg;
      wire       fall    = ~inst_out_reg & prev_out_reg;
      wire       evt     = (rise & ctl2_reg[`ACOC_CTL2_RISE]) | (fall & ctl2_reg[`ACOC_CTL2_FALL]);

      always @(posedge sys_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          ctl_reg      <= `ACOC_CTL1_RST;
          ctl2_reg     <= `ACOC_CTL2_RST;
          raw_sync_reg <= 3'h0;
          inst_out_reg <= 1'b0;
          sync_out_reg <= 1'b0;
          prev_out_reg <= 1'b0;
          flag_reg     <= 1'b0;
        end
        else if (clk_en)
        begin
          if (ctrl_wr_en[i])
          begin
            // Output bit and bit 3 are not writable
            ctl_reg <= {wd[7], 1'b0, wd[5:4], 1'b0, wd[2:0]};
          end
          if (ctrl2_wr_en[i])
            ctl2_reg <= {wd2[7:4], 2'b00, wd2[1:0]};
          raw_sync_reg <= {raw_sync_reg[1:0], raw_cmp_in[i]};
          if (instr_cycle_tick)
            inst_out_reg <= adj;
          if (tclk_fall)
            sync_out_reg <= adj;
          prev_out_reg <= inst_out_reg;
          // Set wins over a simultaneous clear
          flag_reg <= evt | (flag_reg & ~int_flag_clr[i]);
        end
      end

      assign comparator_ctrl_first[i*8 +: 8]  =
        {ctl_reg[7], inst_out_reg, ctl_reg[5:0]};
      assign comparator_ctrl_second[i*8 +: 8] = ctl2_reg;
      assign analog_enable[i]      = en;
      assign speed_power_select[i] = ctl_reg[`ACOC_CTL_SPEED];
      assign hysteresis_enable[i]  = ctl_reg[`ACOC_CTL_HYST];

      assign compare_int_flag[i] = flag_reg;
      assign timer_gate_src[i]   = ext_res;
      // Pin override follows pin enable alone; drive also needs enable
      assign pin_out[i] = ctl_reg[`ACOC_CTL_PIN_EN] ? ext_res : port_latch[i];
      assign pin_oe[i]  = ~pin_direction_bit[i] &
                          (~ctl_reg[`ACOC_CTL_PIN_EN] | en);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Mirror register
  // ----------------------------------------------------------------
  assign output_mirror_reg = {6'h00, comparator_ctrl_first[8+6], comparator_ctrl_first[6]};

endmodule

// file: bench/acoc_chk.sv
// Port assertions for the comparator output control
`timescale 1ns/1ns
module acoc_chk (
  input wire        sys_clk, arst_n, clk_en,
  input wire [1:0]  ctrl_wr_en, int_flag_clr, port_latch, pin_direction_bit,
  input wire [1:0]  analog_enable, speed_power_select, pin_out, pin_oe, compare_int_flag,
  input wire [15:0] ctrl_wr_data, comparator_ctrl_first, comparator_ctrl_second,
  input wire [7:0]  output_mirror_reg
);
  wire [15:0] cf = comparator_ctrl_first;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_mirror_copy: assert property (output_mirror_reg == {6'h0, cf[14], cf[6]}) else $error("mirror");
  chk_enable_level: assert property (analog_enable == {cf[15], cf[7]}) else $error("enable");
  chk_speed_level: assert property (speed_power_select == {cf[10], cf[2]}) else $error("speed");
  chk_pin_drive: assert property (cf[5] && cf[7] && !pin_direction_bit[0] |-> pin_oe[0]) else $error("oe");
  chk_pin_latch: assert property (!cf[5] |-> pin_out[0] == port_latch[0]) else $error("latch");
  chk_write_take: assert property (ctrl_wr_en[0] && clk_en |=>
    (cf[7:0] & 8'hb7) == ($past(ctrl_wr_data[7:0]) & 8'hb7)) else $error("write");
  chk_flag_sticky: assert property (compare_int_flag[0] && !int_flag_clr[0] |=> compare_int_flag[0]) else $error("flag");
  chk_unused_zero: assert property (!cf[3] && !cf[11] && comparator_ctrl_second[3:2] == 2'h0) else $error("unused");
endmodule
bind acoc_comparator_ctrl acoc_chk chk (.*);

// file: bench/acoc_partner.sv
// Timer side model: free-running prescaled clock and gated count
`timescale 1ns/1ns
module acoc_partner (
  output reg       tmr_presc_clk,
  input wire [1:0] timer_gate_src
);
  reg [15:0] cnt_reg = 16'h0;
  initial tmr_presc_clk = 1'b0;
  always #37 tmr_presc_clk = ~tmr_presc_clk;
  // Count on the rising edge, away from the capture edge
  always @(posedge tmr_presc_clk) if (timer_gate_src[0]) cnt_reg <= cnt_reg + 16'h1;
endmodule

// file: bench/analog_comparator_output_control_bench.sv
// Self-checking bench for the comparator output control
`timescale 1ns/1ns
`define CK(n,e,s) begin n_checks++; if ((s) !== (e)) begin bad_count++; $display("ERROR %s exp %h got %h", n, e, s); end end
module analog_comparator_output_control_bench;
  reg         sys_clk = 0, arst_n = 0, clk_en = 1, instr_cycle_tick = 0;
  reg [1:0]   raw_cmp_in = 0, ctrl_wr_en = 0, ctrl2_wr_en = 0, int_flag_clr = 0, port_latch = 0;
  reg [1:0]   pin_direction_bit = 2'h3;
  reg [15:0]  ctrl_wr_data = 0, ctrl2_wr_data = 0;
  wire        tmr_presc_clk;
  wire [15:0] comparator_ctrl_first, comparator_ctrl_second;
  wire [7:0]  output_mirror_reg;
  wire [1:0]  analog_enable, speed_power_select, hysteresis_enable, timer_gate_src, pin_out, pin_oe, compare_int_flag;
  integer     bad_count = 0, n_checks = 0, seed = 95207, i, k;
  acoc_comparator_ctrl dut (.*);
  acoc_partner far (.*);
  always #5 sys_clk = ~sys_clk;
  always @(negedge sys_clk) instr_cycle_tick <= $random(seed);
  function [1:0] adj(input [1:0] r, input p);
    adj = r ^ {p, p};
  endfunction
  task cyc(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  task wr1(input [15:0] d);
  begin
    ctrl_wr_data = d; ctrl_wr_en = 2'h3; cyc(1); ctrl_wr_en = 0; cyc(16);
  end
  endtask
  task summarize;
  begin
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  end
  endtask
  initial begin #60000; bad_count++; summarize; end
  initial begin
    cyc(4); arst_n = 1;
    `CK("ctl1", 16'h0404, comparator_ctrl_first)
    for (i = 0; i < 8; i++) begin k = $random(seed); wr1(k[15:0]);
      `CK("hyst", {k[9], k[1]}, hysteresis_enable)
      `CK("wr", k[15:0] & 16'hb7b7, comparator_ctrl_first & 16'hb7b7) end
    $display("writes done");
    pin_direction_bit = 0;
    for (i = 0; i < 8; i++) begin
      raw_cmp_in = i[1:0]; port_latch = ~i[1:0]; wr1({2{3'b101, i[2], 4'h4}});
      `CK("out", adj(i[1:0], i[2]), {comparator_ctrl_first[14], comparator_ctrl_first[6]})
      `CK("mirror", {6'h0, adj(i[1:0], i[2])}, output_mirror_reg)
      `CK("pin", adj(i[1:0], i[2]), pin_out)
      `CK("gate", adj(i[1:0], i[2]), timer_gate_src)
      `CK("oe", 2'h3, pin_oe)
    end
    wr1(16'h2424);
    `CK("oe_off", 2'h0, pin_oe)
    `CK("en_off", 2'h0, analog_enable)
    $display("polarity done");
    raw_cmp_in = 0; wr1(16'h8484); ctrl2_wr_data = 16'h8080; ctrl2_wr_en = 3; cyc(1); ctrl2_wr_en = 0;
    int_flag_clr = 3; cyc(1); int_flag_clr = 0; cyc(1);
    `CK("ctl2", 16'h8080, comparator_ctrl_second)
    `CK("flag0", 2'h0, compare_int_flag)
    raw_cmp_in = 3; cyc(16);
    `CK("flag1", 2'h3, compare_int_flag)
    int_flag_clr = 3; cyc(1); int_flag_clr = 0; raw_cmp_in = 0; cyc(16);
    `CK("nofall", 2'h0, compare_int_flag)
    $display("flags done");
    wr1(16'h8585); raw_cmp_in = 3; cyc(60);
    `CK("sync", 2'h3, timer_gate_src)
    $display("sync done");
    summarize;
  end
endmodule
